// ===== include/timer_unit_consts.svh
// Register selects, reset values and counts for the triple timer unit
`ifndef TIMER_UNIT_CONSTS_SVH
`define TIMER_UNIT_CONSTS_SVH

// Register select codes (three select lines)
`define RS_CTRL_SHARED   3'h0
`define RS_CTRL_TWO      3'h1
`define RS_STATUS        3'h1

// Reset values
`define PIN_IDLE         22'h1fffff
`define LATCH_RESET      16'hffff
`define CTRL_RESET       8'h00
`define CTRL_ONE_RESET   8'h01
`define COUNT_RESET      16'h0000
`define BYTE_ZERO        8'h00

// Status register field positions
`define STAT_COMPOSITE   7
`define STAT_FLAGS_LSB   0

// Timer three prescaler
`define PRESCALE_LAST    3'h7
`define PRESCALE_ZERO    3'h0
`define PRESCALE_STEP    3'h1

// Counter arithmetic
`define COUNT_STEP16     16'h0001
`define COUNT_STEP8      8'h01

`endif

// ===== include/timer_unit_pkg.sv
// Types shared by the triple timer unit files
package timer_unit_pkg;

   // One control register; the low bit is global hold, register select or timer three prescale
   typedef struct packed {
      logic output_enable_bit;
      logic flag_enable_bit;
      logic mode_bit_c;
      logic mode_bit_b;
      logic mode_bit_a;
      logic split_byte_count_bit;
      logic clock_source_bit;
      logic global_low_bit;
   } ctrl_t;

   // Bus pins after synchronisation
   typedef struct packed {
      logic       enable;
      logic       sel;
      logic       rw;
      logic [2:0] rs;
      logic [7:0] data;
   } bus_pins_t;

endpackage : timer_unit_pkg

// ===== rtl/timer_counter.sv
// One 16-bit down counter with reload, time out and output waveform
`timescale 1ns/1ps
`include "timer_unit_consts.svh"

module timer_counter
   import timer_unit_pkg::*;
#(
   parameter int WIDTH = 16
) (
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   input  wire logic             tick,
   input  wire logic             count_en,
   input  wire logic             init,
   input  wire logic [WIDTH-1:0] latch,
   input  wire ctrl_t            cfg,
   output logic      [WIDTH-1:0] count_q,
   output logic                  timeout,
   output logic                  out_level_q
);

   localparam int HALF = WIDTH / 2;

   logic [WIDTH-1:0] count_d;
   logic             out_level_d;
   logic             shot_done_q;
   logic             shot_done_d;
   logic             single_shot;

   initial begin
      if (WIDTH != 16) begin
         $error("timer_counter serves only a 16-bit counter");
      end
   end

   assign single_shot = !cfg.mode_bit_a && cfg.mode_bit_c;

   always_comb begin
      count_d     = count_q;
      out_level_d = out_level_q;
      shot_done_d = shot_done_q;
      timeout     = 1'b0;
      if (init) begin
         count_d     = latch;
         out_level_d = single_shot && !cfg.split_byte_count_bit;
         shot_done_d = 1'b0;
      end else if (tick && count_en) begin
         if (cfg.split_byte_count_bit) begin
            // Low byte runs L+1 times per high byte step
            if (count_q[HALF-1:0] == '0) begin
               if (count_q[WIDTH-1:HALF] == '0) begin
                  timeout = 1'b1;
                  count_d = latch;
               end else begin
                  count_d = {count_q[WIDTH-1:HALF] - `COUNT_STEP8, latch[HALF-1:0]};
               end
            end else begin
               count_d = {count_q[WIDTH-1:HALF], count_q[HALF-1:0] - `COUNT_STEP8};
            end
            out_level_d = (count_d[WIDTH-1:HALF] == '0) && !timeout && !shot_done_q;
         end else begin
            if (count_q == '0) begin
               timeout = 1'b1;
               count_d = latch;
            end else begin
               count_d = count_q - `COUNT_STEP16;
            end
            if (timeout) begin
               out_level_d = single_shot ? 1'b0 : !out_level_q;
            end
         end
         if (timeout && single_shot) begin
            shot_done_d = 1'b1;
            out_level_d = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         count_q     <= `COUNT_RESET;
         out_level_q <= 1'b0;
         shot_done_q <= 1'b0;
      end else begin
         count_q     <= count_d;
         out_level_q <= out_level_d;
         shot_done_q <= shot_done_d;
      end
   end

endmodule : timer_counter

// ===== rtl/triple_timer_unit.sv
// Three-channel programmable timer: bus registers, flags, sync and control
`timescale 1ns/1ps
`include "timer_unit_consts.svh"

// Behaviour
// - Flag enable bit gates flag onto interrupt
// - Output enable bit clear holds pin low
// - Global hold: reload counters, stop clocks, clear
// - Global hold spares latches and control registers
// - Timer three optional divide-by-8 prescaler
// - Clock source bit picks internal or external
// - 16-bit mode times out after N+1
// - Split mode times out after (L+1)(M+1)
// - Status: flags bits 0-2, composite bit 7
// - Composite is OR of flag-and-enable
// - Any reset condition clears all flags
// - Counter read clears flag after status read
// - Latch write or reload clears own flag
// - Reload copies 16-bit latch into counter
// - Three staging addresses share one register
// - External reset loads latches with maximum
// - Reload on reset, latch write, gate fall
// - Clock after zero reloads counter
// - External clocks sampled by Enable, two stages
// - Bits 1-7 per timer, bit 0 special (hold, register select, timer three prescale)
// - Interrupt pin low exactly when composite set
// - Clock source zero external, one Enable
// - Global hold keeps timers in preset state
// - External reset clears controls, sets hold bit
module triple_timer_unit
   import timer_unit_pkg::*;
#(
   parameter int NUM_TIMERS = 3
) (
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire logic       bus_enable,
   input  wire logic       chip_sel0_n,
   input  wire logic       chip_sel1,
   input  wire logic       read_write,
   input  wire logic [2:0] reg_sel,
   input  wire logic [7:0] data_in,
   output logic      [7:0] data_out,
   output logic            data_oe_n,
   output logic            irq_out,
   output logic            irq_oe_n,
   input  wire logic       reset_pin_n,
   input  wire logic [2:0] ext_tick_n,
   input  wire logic [2:0] gate_n,
   output logic      [2:0] timer_output_pin
);

   localparam int PIN_W = 22;

   initial begin
      if (NUM_TIMERS != 3) begin
         $error("triple_timer_unit decodes exactly three timers");
      end
   end

   // Two-flop synchroniser for every pin input
   logic [PIN_W-1:0] pin_meta_q;
   logic [PIN_W-1:0] pin_sync_q;
   logic [PIN_W-1:0] pin_raw;

   assign pin_raw = {bus_enable, chip_sel0_n, chip_sel1, read_write, reg_sel, data_in,
                     reset_pin_n, ext_tick_n, gate_n};

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pin_meta_q <= `PIN_IDLE;
         pin_sync_q <= `PIN_IDLE;
      end else begin
         pin_meta_q <= pin_raw;
         pin_sync_q <= pin_meta_q;
      end
   end

   bus_pins_t  bus;
   logic       rst_pin_s;
   logic [2:0] tick_s;
   logic [2:0] gate_s;

   assign bus.enable = pin_sync_q[21];
   assign bus.sel    = !pin_sync_q[20] && pin_sync_q[19];
   assign bus.rw     = pin_sync_q[18];
   assign bus.rs     = pin_sync_q[17:15];
   assign bus.data   = pin_sync_q[14:7];
   assign rst_pin_s  = pin_sync_q[6];
   assign tick_s     = pin_sync_q[5:3];
   assign gate_s     = pin_sync_q[2:0];

   // Enable-rate sampling of clock, gate and reset pins
   logic       enable_prev_q;
   logic       e_fall;
   logic [2:0] tick_e1_q, tick_e2_q, gate_e1_q, gate_e2_q;
   logic       rst_e1_q, rst_e2_q;

   // Trailing edge of Enable is the bus strobe and the internal count tick
   assign e_fall = enable_prev_q && !bus.enable;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         enable_prev_q <= 1'b0;
         tick_e1_q     <= '1;
         tick_e2_q     <= '1;
         gate_e1_q     <= '1;
         gate_e2_q     <= '1;
         rst_e1_q      <= 1'b1;
         rst_e2_q      <= 1'b1;
      end else begin
         enable_prev_q <= bus.enable;
         if (e_fall) begin
            tick_e1_q <= tick_s;
            tick_e2_q <= tick_e1_q;
            gate_e1_q <= gate_s;
            gate_e2_q <= gate_e1_q;
            rst_e1_q  <= rst_pin_s;
            rst_e2_q  <= rst_e1_q;
         end
      end
   end

   // Register file state
   ctrl_t       ctrl_q [3];
   ctrl_t       ctrl_d [3];
   logic [15:0] latch_q [3];
   logic [15:0] latch_d [3];
   logic [7:0]  staging_q, staging_d;
   logic [7:0]  lsb_buf_q, lsb_buf_d;
   logic [2:0]  flag_q, flag_d;
   logic [2:0]  armed_q, armed_d;
   logic [7:0]  data_out_q, data_out_d;
   logic [2:0]  pin_q, pin_d;
   logic [2:0]  presc_q, presc_d;

   logic        ext_reset;
   logic        timer_reset;
   logic        wr_strobe, rd_strobe;
   logic [1:0]  sel_idx;
   logic [2:0]  latch_wr;
   logic [2:0]  counter_rd;
   logic [2:0]  ext_fall, gate_fall, src_tick, cnt_tick, count_en, counter_reload;
   logic [2:0]  timeout, out_level;
   logic [15:0] count [3];
   logic        composite;
   logic [7:0]  status;

   assign ext_reset   = !rst_e2_q;
   assign timer_reset = ext_reset || ctrl_q[0].global_low_bit;
   assign wr_strobe   = e_fall && bus.sel && !bus.rw;
   assign rd_strobe   = e_fall && bus.sel && bus.rw;
   assign sel_idx     = bus.rs[2:1] - 2'h1;

   always_comb begin
      latch_wr   = '0;
      counter_rd = '0;
      if (bus.rs[2:1] != 2'h0) begin
         latch_wr[sel_idx]   = wr_strobe && bus.rs[0];
         counter_rd[sel_idx] = rd_strobe && !bus.rs[0];
      end
   end

   // Per-timer clock selection, gating and reload causes
   assign ext_fall  = {3{e_fall}} & tick_e2_q & ~tick_e1_q;
   assign gate_fall = {3{e_fall}} & gate_e2_q & ~gate_e1_q;

   always_comb begin
      for (int i = 0; i < 3; i++) begin
         src_tick[i] = ctrl_q[i].clock_source_bit ? e_fall : ext_fall[i];
         count_en[i] = !timer_reset &&
                       (!gate_e1_q[i] || (!ctrl_q[i].mode_bit_a && ctrl_q[i].mode_bit_c));
         counter_reload[i] = timer_reset ||
                             (gate_fall[i] && !ctrl_q[i].mode_bit_a) ||
                             (latch_wr[i] && !ctrl_q[i].mode_bit_b);
      end
      cnt_tick[1:0] = src_tick[1:0];
      // Prescaler sits after clock selection, so it divides either source
      cnt_tick[2] = ctrl_q[2].global_low_bit ?
                    (src_tick[2] && presc_q == `PRESCALE_LAST) : src_tick[2];
      presc_d = presc_q;
      if (timer_reset) begin
         presc_d = `PRESCALE_ZERO;
      end else if (src_tick[2] && ctrl_q[2].global_low_bit) begin
         presc_d = presc_q + `PRESCALE_STEP;
      end
   end

   for (genvar g = 0; g < 3; g++) begin : g_timer
      timer_counter #(
         .WIDTH       (16)
      ) u_counter (
         .core_clk    (core_clk),
         .rst_n       (rst_n),
         .tick        (cnt_tick[g]),
         .count_en    (count_en[g]),
         .init        (counter_reload[g]),
         .latch       (latch_q[g]),
         .cfg         (ctrl_q[g]),
         .count_q     (count[g]),
         .timeout     (timeout[g]),
         .out_level_q (out_level[g])
      );
   end

   // Status and interrupt
   assign composite = |(flag_q & {ctrl_q[2].flag_enable_bit,
                                  ctrl_q[1].flag_enable_bit,
                                  ctrl_q[0].flag_enable_bit});
   assign status    = {composite, 4'h0, flag_q};
   assign irq_out   = 1'b0;
   assign irq_oe_n  = !composite;

   // Register writes, flags and read data
   always_comb begin
      ctrl_d     = ctrl_q;
      latch_d    = latch_q;
      staging_d  = staging_q;
      lsb_buf_d  = lsb_buf_q;
      flag_d     = flag_q;
      armed_d    = armed_q;
      if (ext_reset) begin
         for (int i = 0; i < 3; i++) begin
            latch_d[i] = `LATCH_RESET;
            ctrl_d[i]  = ctrl_t'(`CTRL_RESET);
         end
         ctrl_d[0] = ctrl_t'(`CTRL_ONE_RESET);
      end else if (wr_strobe) begin
         // Writes stay open while the hold bit is set
         if (bus.rs == `RS_CTRL_SHARED) begin
            if (ctrl_q[1].global_low_bit) begin
               ctrl_d[0] = ctrl_t'(bus.data);
            end else begin
               ctrl_d[2] = ctrl_t'(bus.data);
            end
         end else if (bus.rs == `RS_CTRL_TWO) begin
            ctrl_d[1] = ctrl_t'(bus.data);
         end else if (!bus.rs[0]) begin
            staging_d = bus.data;
         end else begin
            latch_d[sel_idx] = {staging_q, bus.data};
         end
      end
      for (int i = 0; i < 3; i++) begin
         if (rd_strobe && bus.rs == `RS_STATUS && flag_q[i]) begin
            armed_d[i] = 1'b1;
         end
         if ((counter_rd[i] && armed_q[i]) ||
             latch_wr[i] || counter_reload[i]) begin
            flag_d[i]  = 1'b0;
            armed_d[i] = 1'b0;
         end
         // A time out in the clearing cycle is kept
         if (timeout[i]) begin
            flag_d[i] = 1'b1;
         end
         if (timer_reset) begin
            flag_d[i]  = 1'b0;
            armed_d[i] = 1'b0;
         end
         if (counter_rd[i]) begin
            lsb_buf_d = count[i][7:0];
         end
      end
   end

   always_comb begin
      data_out_d = `BYTE_ZERO;
      if (bus.rs == `RS_STATUS) begin
         data_out_d = status;
      end else if (bus.rs[0] && bus.rs != `RS_CTRL_TWO) begin
         data_out_d = lsb_buf_q;
      end else if (bus.rs != `RS_CTRL_SHARED) begin
         data_out_d = count[sel_idx][15:8];
      end
      for (int i = 0; i < 3; i++) begin
         pin_d[i] = out_level[i] && ctrl_q[i].output_enable_bit &&
                    !timer_reset;
      end
   end

   assign data_oe_n        = !(bus.enable && bus.sel && bus.rw);
   assign data_out         = data_out_q;
   assign timer_output_pin = pin_q;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         for (int i = 0; i < 3; i++) begin
            ctrl_q[i]  <= ctrl_t'(`CTRL_RESET);
            latch_q[i] <= `LATCH_RESET;
         end
         ctrl_q[0]  <= ctrl_t'(`CTRL_ONE_RESET);
         staging_q  <= `BYTE_ZERO;
         lsb_buf_q  <= `BYTE_ZERO;
         flag_q     <= '0;
         armed_q    <= '0;
         data_out_q <= `BYTE_ZERO;
         pin_q      <= '0;
         presc_q    <= `PRESCALE_ZERO;
      end else begin
         ctrl_q     <= ctrl_d;
         latch_q    <= latch_d;
         staging_q  <= staging_d;
         lsb_buf_q  <= lsb_buf_d;
         flag_q     <= flag_d;
         armed_q    <= armed_d;
         data_out_q <= data_out_d;
         pin_q      <= pin_d;
         presc_q    <= presc_d;
      end
   end

endmodule : triple_timer_unit

// ===== verif/timer_unit_chk.sv
// Port-level assertions for the triple timer unit
`timescale 1ns/1ps

module timer_unit_chk (
   input wire logic       core_clk,
   input wire logic       rst_n,
   input wire logic       bus_enable,
   input wire logic       chip_sel0_n,
   input wire logic       chip_sel1,
   input wire logic       read_write,
   input wire logic [2:0] reg_sel,
   input wire logic       reset_pin_n,
   input wire logic [7:0] data_out,
   input wire logic       data_oe_n,
   input wire logic       irq_out,
   input wire logic       irq_oe_n,
   input wire logic [2:0] timer_output_pin
);
   logic       en_q;
   logic [7:0] fall_q;
   logic [7:0] fall_d;
   logic [7:0] low_q;
   logic [7:0] low_d;

   // Saturating counts, so a long idle stretch never wraps into a false window
   always_comb begin
      fall_d = (fall_q == 8'hff) ? fall_q : fall_q + 8'h01;
      low_d  = (low_q == 8'hff) ? low_q : low_q + 8'h01;
      if (en_q && !bus_enable) begin
         fall_d = 8'h00;
      end
      if (!rst_n) begin
         fall_d = 8'hff;
      end
      if (reset_pin_n) begin
         low_d = 8'h00;
      end
   end

   always_ff @(posedge core_clk) begin
      en_q   <= bus_enable;
      fall_q <= fall_d;
      low_q  <= low_d;
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   irq_pin_idle_a: assert property (irq_out == 1'b0)
      else $error("irq level driven");
   reset_quiet_a: assert property ($rose(rst_n) |-> timer_output_pin == 3'h0 && irq_oe_n)
      else $error("outputs active after reset");
   pin_reset_quiet_a: assert property (low_q >= 8'h50 |-> timer_output_pin == 3'h0 && irq_oe_n)
      else $error("outputs active under reset pin");
   out_after_tick_a: assert property ($changed(timer_output_pin) |-> fall_q <= 8'h0a)
      else $error("output moved without enable fall");
   irq_after_tick_a: assert property ($changed(irq_oe_n) |-> fall_q <= 8'h0a)
      else $error("irq moved without enable fall");
   status_unused_a: assert property ((reg_sel == 3'h1 && read_write && bus_enable) [*6]
      |-> data_out[6:3] == 4'h0) else $error("status spare bits set");
   status_composite_a: assert property ((reg_sel == 3'h1 && read_write && bus_enable) [*6]
      |-> data_out[7] == !irq_oe_n) else $error("composite differs from irq");
   bus_release_a: assert property (!bus_enable [*4] |-> data_oe_n)
      else $error("data driven outside enable");
   read_drive_a: assert property ((!chip_sel0_n && chip_sel1 && read_write && bus_enable) [*4]
      |-> !data_oe_n) else $error("read data not driven");
endmodule : timer_unit_chk

bind triple_timer_unit timer_unit_chk u_chk (.core_clk, .rst_n, .bus_enable, .chip_sel0_n,
   .chip_sel1, .read_write,
   .reg_sel, .reset_pin_n, .data_out, .data_oe_n, .irq_out, .irq_oe_n, .timer_output_pin);

// ===== verif/bus_master_model.sv
// Bus master model: one Enable cycle per register access, deselected accesses for idle
`timescale 1ns/1ps

module bus_master_model (
   input  wire logic       core_clk,
   input  wire logic [7:0] data_out,
   output logic            bus_enable,
   output logic            chip_sel0_n,
   output logic            chip_sel1,
   output logic            read_write,
   output logic [2:0]      reg_sel,
   output logic [7:0]      data_in
);
   initial begin
      bus_enable  = 1'b0;
      chip_sel0_n = 1'b1;
      chip_sel1   = 1'b0;
      read_write  = 1'b1;
      reg_sel     = 3'h0;
      data_in     = 8'h5a;
   end

   // Select and address hold through the low phase: the device acts on the
   // Enable fall only after synchronising it
   task automatic access(input logic sel, input logic rw, input logic [2:0] rs,
                         input logic [7:0] wd, output logic [7:0] rd);
      @(posedge core_clk);
      chip_sel0_n <= ~sel;
      chip_sel1   <= sel;
      read_write  <= rw;
      reg_sel     <= rs;
      data_in     <= rw ? ~data_in : wd;
      bus_enable  <= 1'b1;
      repeat (8) @(posedge core_clk);
      rd = data_out;
      bus_enable <= 1'b0;
      repeat (8) @(posedge core_clk);
      chip_sel0_n <= 1'b1;
      chip_sel1   <= 1'b0;
      data_in     <= ~data_in;
   endtask : access

   task automatic idle(input int n);
      logic [7:0] rd;
      repeat (n) access(1'b0, 1'b1, 3'h0, 8'h00, rd);
   endtask : idle
endmodule : bus_master_model

// ===== verif/triple_timer_unit_bench.sv
// Self-checking bench for the triple timer unit
`timescale 1ns/1ps

module triple_timer_unit_bench;
   logic       core_clk;
   logic       rst_n;
   logic       reset_pin_n;
   logic [2:0] ext_tick_n;
   logic [2:0] gate_n;
   logic       bus_enable;
   logic       chip_sel0_n;
   logic       chip_sel1;
   logic       read_write;
   logic [2:0] reg_sel;
   logic [7:0] data_in;
   logic [7:0] data_out;
   logic       data_oe_n;
   logic       irq_out;
   logic       irq_oe_n;
   logic [2:0] timer_output_pin;
   logic       pin_seen;
   logic [7:0] rd;
   int         errors;
   int         checked;
   int         cyc;

   triple_timer_unit u_dut (.core_clk, .rst_n, .bus_enable, .chip_sel0_n, .chip_sel1,
      .read_write, .reg_sel, .data_in, .data_out, .data_oe_n, .irq_out, .irq_oe_n,
      .reset_pin_n, .ext_tick_n, .gate_n, .timer_output_pin);
   bus_master_model u_bus (.core_clk, .data_out, .bus_enable, .chip_sel0_n, .chip_sel1,
      .read_write, .reg_sel, .data_in);

   initial core_clk = 1'b0;
   always #2 core_clk = ~core_clk;

   task automatic summarize;
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : summarize

   // Sticky watch on timer one output, sampled every cycle
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (timer_output_pin[0] === 1'b1) begin
         pin_seen <= 1'b1;
      end
      if (cyc == 8000) begin
         errors++;
         summarize();
      end
   end

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk8

   task automatic chk1(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk1

   task automatic wr(input logic [2:0] rs, input logic [7:0] d);
      u_bus.access(1'b1, 1'b0, rs, d, rd);
   endtask : wr

   task automatic peek(input logic [2:0] rs);
      u_bus.access(1'b1, 1'b1, rs, 8'h00, rd);
   endtask : peek

   task automatic rdr(input logic [2:0] rs, input logic [7:0] exp);
      peek(rs);
      chk8(rd, exp);
   endtask : rdr

   task automatic ld(input logic [2:0] rs, input logic [7:0] msb, input logic [7:0] lsb);
      wr(rs - 3'h1, msb);
      wr(rs, lsb);
   endtask : ld

   task automatic t_reset;
      rdr(3'h1, 8'h00);
      rdr(3'h2, 8'hff);
      rdr(3'h3, 8'hff);
   endtask : t_reset

   task automatic t_count16;
      gate_n <= 3'h0;
      wr(3'h1, 8'h01);
      ld(3'h3, 8'h00, 8'h03);
      wr(3'h0, 8'h43);
      wr(3'h0, 8'h42);
      rdr(3'h1, 8'h00);
      u_bus.idle(4);
      rdr(3'h1, 8'h81);
      chk1(irq_oe_n, 1'b0);
      wr(3'h0, 8'h02);
      rdr(3'h1, 8'h01);
      chk1(irq_oe_n, 1'b1);
      chk1(pin_seen, 1'b0);
      wr(3'h0, 8'h82);
      u_bus.idle(6);
      chk1(pin_seen, 1'b1);
   endtask : t_count16

   task automatic t_clear;
      gate_n <= 3'h1;
      u_bus.idle(6);
      rdr(3'h1, 8'h01);
      peek(3'h2);
      rdr(3'h1, 8'h00);
      gate_n <= 3'h0;
      u_bus.idle(10);
      gate_n <= 3'h1;
      u_bus.idle(6);
      peek(3'h2);
      rdr(3'h1, 8'h01);
      ld(3'h5, 8'h00, 8'h05);
      rdr(3'h1, 8'h01);
      ld(3'h3, 8'h00, 8'h03);
      rdr(3'h1, 8'h00);
   endtask : t_clear

   task automatic t_hold;
      gate_n <= 3'h0;
      u_bus.idle(10);
      wr(3'h0, 8'h83);
      rdr(3'h1, 8'h00);
      chk8({5'h00, timer_output_pin}, 8'h00);
      rdr(3'h2, 8'h00);
      rdr(3'h3, 8'h03);
      ld(3'h3, 8'h12, 8'h34);
      rdr(3'h2, 8'h12);
      rdr(3'h3, 8'h34);
   endtask : t_hold

   task automatic t_ext;
      wr(3'h1, 8'h41);
      ld(3'h5, 8'h00, 8'h01);
      wr(3'h0, 8'h82);
      u_bus.idle(8);
      rdr(3'h1, 8'h00);
      // Each level lasts two Enable periods so every one is sampled
      repeat (3) begin
         ext_tick_n <= 3'h0;
         u_bus.idle(2);
         ext_tick_n <= 3'h7;
         u_bus.idle(2);
      end
      u_bus.idle(4);
      rdr(3'h1, 8'h82);
      chk1(irq_oe_n, 1'b0);
   endtask : t_ext

   task automatic t_prescale;
      wr(3'h0, 8'h83);
      wr(3'h1, 8'h00);
      wr(3'h0, 8'h43);
      ld(3'h7, 8'h00, 8'h00);
      wr(3'h1, 8'h01);
      wr(3'h0, 8'h82);
      rdr(3'h1, 8'h00);
      u_bus.idle(3);
      rdr(3'h1, 8'h00);
      u_bus.idle(8);
      rdr(3'h1, 8'h84);
   endtask : t_prescale

   // Timer two in split mode, latch 0101: time out on the fourth tick
   task automatic t_split;
      wr(3'h0, 8'h83);
      wr(3'h1, 8'h46);
      wr(3'h0, 8'h00);
      ld(3'h5, 8'h01, 8'h01);
      wr(3'h1, 8'h47);
      wr(3'h0, 8'h02);
      rdr(3'h1, 8'h00);
      u_bus.idle(2);
      rdr(3'h1, 8'h00);
      rdr(3'h1, 8'h82);
   endtask : t_split

   task automatic t_pin;
      reset_pin_n <= 1'b0;
      u_bus.idle(6);
      reset_pin_n <= 1'b1;
      u_bus.idle(3);
      rdr(3'h1, 8'h00);
      rdr(3'h2, 8'hff);
      rdr(3'h3, 8'hff);
      chk1(irq_oe_n, 1'b1);
   endtask : t_pin

   initial begin
      rst_n       = 1'b0;
      reset_pin_n = 1'b1;
      ext_tick_n  = 3'h7;
      gate_n      = 3'h7;
      pin_seen    = 1'b0;
      errors      = 0;
      checked     = 0;
      cyc         = 0;
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      t_reset();
      t_count16();
      t_clear();
      t_hold();
      t_ext();
      t_prescale();
      t_split();
      t_pin();
      summarize();
   end
endmodule : triple_timer_unit_bench
